// ===== pkg/swb_map.svh
`ifndef SWB_MAP_SVH
`define SWB_MAP_SVH
// function command codes
`define SWB_CMD_WR_STOP 8'h4B
`define SWB_CMD_WR_OPEN 8'h5A
`define SWB_CMD_WR_ONLY 8'h69
`define SWB_CMD_WR_ONLY_STOP 8'h78
`define SWB_CMD_RD_STOP 8'h87
`define SWB_CMD_WR_RD 8'h2D
`define SWB_CMD_CFG_WR 8'hD2
`define SWB_CMD_CFG_RD 8'hE1
`define SWB_CMD_SLEEP 8'h1E
// speed configuration byte
`define SWB_CFG_RST 8'h01
`define SWB_SPD_100K 2'h0
`define SWB_SPD_400K 2'h1
`define SWB_SPD_1M 2'h2
// status bytes
`define SWB_ERR_START 3
`define SWB_ERR_ADDR 1
`define SWB_ERR_CRC 0
`define SWB_WB_NEVER 8'hFF
`define SWB_READ_IDLE 8'hFF
`define SWB_CRC_POLY 16'hA001
// timing
`define SWB_CLK_MHZ 100
`define SWB_T100K_NS 5250
`define SWB_T400K_NS 1250
`define SWB_T1M_NS 500
`define SWB_NS2CYC(ns) ((((ns) * `SWB_CLK_MHZ) + 999) / 1000)
// host register map
`define SWB_REG_DATA 12'h000
`define SWB_REG_CTRL 12'h004
`define SWB_REG_STAT 12'h008
`define SWB_CTL_RESET 0
`define SWB_CTL_POLL 1
`define SWB_CTL_READ 2
`define SWB_CTL_CRC 3
`define SWB_STA_BUSY 0
`define SWB_STA_POLL 1
`endif

// ===== pkg/swb_pkg.sv
`default_nettype none
`include "swb_map.svh"
package swb_pkg;
  typedef enum logic [3:0] {D_IDLE, D_CMD, D_PARAM, D_CFGW, D_CFGR, D_EXEC, D_STAT,
    D_SLEEP} swb_dev_st_t;
  typedef enum logic [2:0] {F_ADDR, F_WLEN, F_WDATA, F_RLEN, F_CRCL, F_CRCH} swb_fld_t;
  typedef enum logic [3:0] {I_IDLE, I_STA, I_LOW, I_HIGH, I_RS1, I_RS2, I_SP1, I_SP2,
    I_SP3, I_FIN} swb_i2c_st_t;
  typedef enum logic [1:0] {B_ADDR_W, B_ADDR_R, B_WDATA, B_RDATA} swb_bk_t;

  // crc-16 byte step, lsb first, reflected polynomial
  function automatic logic [15:0] swb_crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `SWB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : swb_crc_upd
endpackage : swb_pkg
`default_nettype wire

// ===== pkg/swb_link_if.sv
`default_nettype none
interface swb_link_if;
  logic sel;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic rd_req;
  logic rd_byte;
  logic rd_ack;
  logic [7:0] rd_data;
  modport dev (input sel, input wr_stb, input wr_byte, input rd_req, input rd_byte,
    output rd_ack, output rd_data);
  modport host (output sel, output wr_stb, output wr_byte, output rd_req, output rd_byte,
    input rd_ack, input rd_data);
endinterface : swb_link_if
`default_nettype wire

// ===== verilog/swb_dev.sv
// The implementer's own choices: the APB slave port and the register offsets.
`default_nettype none
`include "swb_map.svh"
// Function
// R1: 4Bh: start, write address, data, stop
// R2: write length sets count of data bytes
// R3: 5Ah: start, address, data, no stop
// R4: 69h: data on open transaction, no stop
// R5: 78h: data then stop, chains open writes
// R6: 87h: start, read address, read, stop
// R7: 2Dh: write, repeated start, read, stop
// R8: ack each read byte, nack last
// R9: config and sleep: no bus, no status
// R10: D2h: next byte becomes speed config
// R11: config resets 01h, speed field codes
// R12: E1h: return current speed config byte
// R13: 1Eh: sleep, ignore link, like pin
// R14: wake pin rising edge leaves sleep
// R15: bytes msb first, one clock per bit
// R16: sda changes only while scl low
// R17: equal high and low half periods
// R18: wait while slave holds scl low
// R19: time high phase from actual release
// R20: zero length: error flag, go idle; code enters D_STAT, not D_IDLE
// R21: crc-16 check, mismatch sets error
// R22: polls read 1 while busy, then 0
// R23: error byte bits, first nack index
module swb_dev (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // single-wire link
  swb_link_if.dev lnk,
  // i2c pins
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // power and status pins
  input wire logic i_sleep_req,
  input wire logic i_wake_req,
  output logic o_awake,
  output logic o_error_flag_n
);
  import swb_pkg::*;

  swb_dev_st_t st_q;
  swb_fld_t fld_q;
  swb_i2c_st_t ist_q;
  swb_bk_t bk_q;
  logic [7:0] cmd_q, addr_q, wlen_q, rlen_q, crcl_q, cfg_q, widx_q, ridx_q;
  logic [15:0] crc_q;
  logic [7:0] wbuf [0:254];
  logic [7:0] rbuf [0:254];
  logic poll0_q, go_q, done_q, pkt_crc_q, rd_ack_q, awake_q, err_n_q;
  logic slp_prev_q, wake_prev_q, scl_oe_q, sda_oe_q, drv_lvl_q;
  logic [7:0] rd_data_q, wb_q, sh_q, cnt_q;
  logic [3:0] bitn_q;
  logic [9:0] tmr_q, half_c;
  logic [7:0] ierr_q;
  logic tdone, wbit, ack_end, sleep_go, wake_go;
  logic [7:0] b;

  assign b = lnk.wr_byte;
  assign tdone = (tmr_q == 10'h000);
  assign sleep_go = slp_prev_q & ~i_sleep_req;
  assign wake_go = ~wake_prev_q & i_wake_req; // R14
  assign ack_end = (ist_q == I_HIGH) && i_scl && tdone && (bitn_q == 4'h8);

  //////////////////////////////////////////////////////////////////////////////
  // speed select
  always_comb begin
    case (cfg_q[1:0])
      `SWB_SPD_400K: half_c = 10'(`SWB_NS2CYC(`SWB_T400K_NS)); // R17
      `SWB_SPD_1M: half_c = 10'(`SWB_NS2CYC(`SWB_T1M_NS)); // R17
      default: half_c = 10'(`SWB_NS2CYC(`SWB_T100K_NS)); // R17
    endcase
  end

  // level put on sda during the low phase of the current bit
  always_comb begin
    if (bitn_q != 4'h8) begin
      wbit = (bk_q == B_RDATA) ? 1'b1 : sh_q[7]; // R15
    end else if (bk_q == B_RDATA) begin
      wbit = (cnt_q == 8'(rlen_q - 8'h01)); // R8
    end else begin
      wbit = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command engine
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q <= D_IDLE;
      fld_q <= F_ADDR;
      cmd_q <= 8'h00;
      addr_q <= 8'h00;
      wlen_q <= 8'h00;
      rlen_q <= 8'h00;
      crcl_q <= 8'h00;
      crc_q <= 16'h0000;
      widx_q <= 8'h00;
      cfg_q <= `SWB_CFG_RST; // R11
      go_q <= 1'b0;
      pkt_crc_q <= 1'b0;
      err_n_q <= 1'b1;
    end else begin
      go_q <= 1'b0;
      if (st_q == D_SLEEP) begin
        if (wake_go) begin
          st_q <= D_IDLE; // R14
        end
      end else if (sleep_go) begin
        st_q <= D_SLEEP; // R13
      end else if (lnk.sel) begin
        st_q <= D_CMD;
        pkt_crc_q <= 1'b0;
        err_n_q <= 1'b1;
      end else begin
        case (st_q)
          D_CMD: if (lnk.wr_stb) begin
            crc_q <= swb_crc_upd(16'h0000, b); // R21
            cmd_q <= b;
            case (b)
              `SWB_CMD_WR_STOP, `SWB_CMD_WR_OPEN, `SWB_CMD_RD_STOP, `SWB_CMD_WR_RD: begin
                fld_q <= F_ADDR;
                st_q <= D_PARAM;
              end
              `SWB_CMD_WR_ONLY, `SWB_CMD_WR_ONLY_STOP: begin
                fld_q <= F_WLEN;
                st_q <= D_PARAM;
              end
              `SWB_CMD_CFG_WR: st_q <= D_CFGW; // R10
              `SWB_CMD_CFG_RD: st_q <= D_CFGR; // R12
              `SWB_CMD_SLEEP: st_q <= D_SLEEP; // R13
              default: begin
                err_n_q <= 1'b0;
                st_q <= D_IDLE;
              end
            endcase
          end
          D_PARAM: if (lnk.wr_stb) begin
            if (fld_q != F_CRCL && fld_q != F_CRCH) begin
              crc_q <= swb_crc_upd(crc_q, b); // R21
            end
            case (fld_q)
              F_ADDR: begin
                addr_q <= b;
                fld_q <= (cmd_q == `SWB_CMD_RD_STOP) ? F_RLEN : F_WLEN;
              end
              F_WLEN: begin
                wlen_q <= b; // R2
                widx_q <= 8'h00;
                fld_q <= F_WDATA;
                if (b == 8'h00) begin
                  err_n_q <= 1'b0; // R20
                  st_q <= D_STAT;
                end
              end
              F_WDATA: begin
                widx_q <= 8'(widx_q + 8'h01);
                if (widx_q == 8'(wlen_q - 8'h01)) begin
                  fld_q <= (cmd_q == `SWB_CMD_WR_RD) ? F_RLEN : F_CRCL; // R2
                end
              end
              F_RLEN: begin
                rlen_q <= b;
                fld_q <= F_CRCL;
                if (b == 8'h00) begin
                  err_n_q <= 1'b0; // R20
                  st_q <= D_STAT;
                end
              end
              F_CRCL: begin
                crcl_q <= b;
                fld_q <= F_CRCH;
              end
              default: begin
                if ({b, crcl_q} == ~crc_q) begin
                  go_q <= 1'b1;
                  st_q <= D_EXEC;
                end else begin
                  pkt_crc_q <= 1'b1; // R21
                  err_n_q <= 1'b0; // R21
                  st_q <= D_STAT;
                end
              end
            endcase
          end
          D_CFGW: if (lnk.wr_stb) begin
            cfg_q <= {6'h00, b[1:0]}; // R11
            st_q <= D_IDLE; // R9
          end
          D_EXEC: if (done_q) begin
            st_q <= D_STAT;
            if (ierr_q != 8'h00) begin
              err_n_q <= 1'b0;
            end
          end
          D_IDLE, D_CFGR, D_STAT: st_q <= st_q;
          default: st_q <= D_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (st_q == D_PARAM && fld_q == F_WDATA && lnk.wr_stb && !lnk.sel) begin
      wbuf[widx_q] <= b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read slots toward the host
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_ack_q <= 1'b0;
      rd_data_q <= `SWB_READ_IDLE;
      poll0_q <= 1'b0;
      ridx_q <= 8'h00;
    end else begin
      rd_ack_q <= lnk.rd_req && (st_q != D_SLEEP); // R13
      if (lnk.sel || st_q != D_STAT) begin
        poll0_q <= 1'b0;
        ridx_q <= 8'h00;
      end
      if (lnk.rd_req) begin
        rd_data_q <= `SWB_READ_IDLE;
        if (!lnk.rd_byte) begin
          rd_data_q <= (st_q == D_EXEC) ? 8'h01 : 8'h00; // R22
          if (st_q == D_STAT) begin
            poll0_q <= 1'b1;
          end
        end else if (st_q == D_CFGR) begin
          rd_data_q <= cfg_q; // R12
        end else if (st_q == D_STAT && poll0_q) begin
          ridx_q <= 8'(ridx_q + 8'h01);
          case (ridx_q)
            8'h00: rd_data_q <= ierr_q | {7'h00, pkt_crc_q}; // R23
            8'h01: rd_data_q <= wb_q; // R23
            default: rd_data_q <= rbuf[8'(ridx_q - 8'h02)];
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // i2c master sequencer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ist_q <= I_IDLE;
      bk_q <= B_ADDR_W;
      tmr_q <= 10'h000;
      bitn_q <= 4'h0;
      sh_q <= 8'h00;
      cnt_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
      ierr_q <= 8'h00;
      wb_q <= `SWB_WB_NEVER;
    end else begin
      done_q <= 1'b0;
      if (tmr_q != 10'h000) begin
        tmr_q <= 10'(tmr_q - 10'h001);
      end
      if (st_q == D_SLEEP) begin
        ist_q <= I_IDLE; // R13
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (lnk.sel && ist_q == I_IDLE) begin
        ierr_q <= 8'h00;
        wb_q <= `SWB_WB_NEVER; // R23
      end else begin
        case (ist_q)
          I_IDLE: if (go_q) begin
            bitn_q <= 4'h0;
            cnt_q <= 8'h00;
            tmr_q <= 10'(half_c - 10'h001);
            if (cmd_q == `SWB_CMD_WR_ONLY || cmd_q == `SWB_CMD_WR_ONLY_STOP) begin
              bk_q <= B_WDATA; // R4 R5
              sh_q <= wbuf[0];
              wb_q <= 8'h00;
              scl_oe_q <= 1'b1;
              ist_q <= I_LOW;
            end else if (!i_scl) begin
              ierr_q[`SWB_ERR_START] <= 1'b1; // R23
              ist_q <= I_FIN;
            end else begin
              bk_q <= (cmd_q == `SWB_CMD_RD_STOP) ? B_ADDR_R : B_ADDR_W; // R6
              sh_q <= {addr_q[6:0], cmd_q == `SWB_CMD_RD_STOP};
              wb_q <= 8'h00;
              sda_oe_q <= 1'b1; // R16
              ist_q <= I_STA;
            end
          end
          I_STA: if (tdone) begin
            scl_oe_q <= 1'b1;
            tmr_q <= 10'(half_c - 10'h001);
            ist_q <= I_LOW;
          end
          I_LOW: begin
            sda_oe_q <= ~wbit; // R16
            if (tdone) begin
              scl_oe_q <= 1'b0;
              tmr_q <= 10'(half_c - 10'h001);
              ist_q <= I_HIGH;
            end
          end
          I_HIGH: begin
            if (!i_scl) begin
              tmr_q <= 10'(half_c - 10'h001); // R18 R19
            end else if (tdone) begin
              scl_oe_q <= 1'b1;
              tmr_q <= 10'(half_c - 10'h001);
              ist_q <= I_LOW;
              if (bitn_q != 4'h8) begin
                sh_q <= {sh_q[6:0], i_sda}; // R15
                bitn_q <= 4'(bitn_q + 4'h1);
              end else begin
                bitn_q <= 4'h0;
                case (bk_q)
                  B_ADDR_W, B_ADDR_R: begin
                    cnt_q <= 8'h00;
                    sh_q <= wbuf[0];
                    bk_q <= (bk_q == B_ADDR_W) ? B_WDATA : B_RDATA;
                    if (i_sda) begin
                      ierr_q[`SWB_ERR_ADDR] <= 1'b1; // R23
                      ist_q <= I_SP1;
                    end
                  end
                  B_WDATA: begin
                    cnt_q <= 8'(cnt_q + 8'h01);
                    sh_q <= wbuf[8'(cnt_q + 8'h01)];
                    if (i_sda) begin
                      wb_q <= 8'(cnt_q + 8'h01); // R23
                      ist_q <= I_SP1;
                    end else if (cnt_q == 8'(wlen_q - 8'h01)) begin
                      if (cmd_q == `SWB_CMD_WR_RD) begin
                        ist_q <= I_RS1; // R7
                      end else if (cmd_q == `SWB_CMD_WR_OPEN || cmd_q == `SWB_CMD_WR_ONLY) begin
                        ist_q <= I_FIN; // R3 R4
                      end else begin
                        ist_q <= I_SP1; // R1 R5
                      end
                    end
                  end
                  default: begin
                    cnt_q <= 8'(cnt_q + 8'h01);
                    if (cnt_q == 8'(rlen_q - 8'h01)) begin
                      ist_q <= I_SP1; // R6 R7
                    end
                  end
                endcase
              end
            end
          end
          I_RS1: begin
            sda_oe_q <= 1'b0;
            if (tdone) begin
              scl_oe_q <= 1'b0;
              tmr_q <= 10'(half_c - 10'h001);
              ist_q <= I_RS2;
            end
          end
          I_RS2: begin
            if (!i_scl) begin
              tmr_q <= 10'(half_c - 10'h001);
            end else if (tdone) begin
              sda_oe_q <= 1'b1; // R7
              bk_q <= B_ADDR_R;
              sh_q <= {addr_q[6:0], 1'b1};
              tmr_q <= 10'(half_c - 10'h001);
              ist_q <= I_STA;
            end
          end
          I_SP1: begin
            sda_oe_q <= 1'b1;
            if (tdone) begin
              scl_oe_q <= 1'b0;
              tmr_q <= 10'(half_c - 10'h001);
              ist_q <= I_SP2;
            end
          end
          I_SP2: begin
            if (!i_scl) begin
              tmr_q <= 10'(half_c - 10'h001);
            end else if (tdone) begin
              sda_oe_q <= 1'b0; // R16
              tmr_q <= 10'(half_c - 10'h001);
              ist_q <= I_SP3;
            end
          end
          I_SP3: if (tdone) begin
            ist_q <= I_FIN;
          end
          default: begin
            done_q <= 1'b1;
            ist_q <= I_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (ack_end && bk_q == B_RDATA) begin
      rbuf[cnt_q] <= sh_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power pins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      slp_prev_q <= 1'b1;
      wake_prev_q <= 1'b1;
      awake_q <= 1'b0;
      drv_lvl_q <= 1'b0;
    end else begin
      slp_prev_q <= i_sleep_req;
      wake_prev_q <= i_wake_req;
      awake_q <= (st_q != D_SLEEP);
      drv_lvl_q <= 1'b0;
    end
  end

  assign lnk.rd_ack = rd_ack_q;
  assign lnk.rd_data = rd_data_q;
  assign o_scl_o = drv_lvl_q;
  assign o_sda_o = drv_lvl_q;
  assign o_scl_oe = scl_oe_q;
  assign o_sda_oe = sda_oe_q;
  assign o_awake = awake_q;
  assign o_error_flag_n = err_n_q;
endmodule : swb_dev
`default_nettype wire

// ===== verilog/swb_host.sv
`default_nettype none
`include "swb_map.svh"
module swb_host (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // single-wire link
  swb_link_if.host lnk
);
  import swb_pkg::*;

  logic pready_q, pslverr_q, sel_q, wr_stb_q, rd_req_q, rd_byte_q;
  logic wait_q, poll_q, pollbit_q;
  logic [1:0] crcph_q;
  logic [7:0] wr_byte_q, rxd_q;
  logic [15:0] crc_q;
  logic [31:0] prdata_q;
  logic busy, wr_acc, mapped;

  assign busy = wait_q | (crcph_q != 2'h0) | rd_req_q;
  assign wr_acc = i_psel & i_penable & pready_q & i_pwrite;
  assign mapped = (i_paddr == `SWB_REG_DATA) || (i_paddr == `SWB_REG_CTRL) ||
    (i_paddr == `SWB_REG_STAT);

  //////////////////////////////////////////////////////////////////////////////
  // apb: one wait-free access cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= i_psel & ~i_penable;
      pslverr_q <= i_psel & ~i_penable & ~mapped;
      prdata_q <= 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
        case (i_paddr)
          `SWB_REG_DATA: prdata_q <= {24'h000000, rxd_q};
          `SWB_REG_STAT: prdata_q <= {30'h0, pollbit_q, busy};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link sequencing
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sel_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_byte_q <= 8'h00;
      rd_req_q <= 1'b0;
      rd_byte_q <= 1'b0;
      wait_q <= 1'b0;
      poll_q <= 1'b0;
      pollbit_q <= 1'b0;
      rxd_q <= 8'h00;
      crc_q <= 16'h0000;
      crcph_q <= 2'h0;
    end else begin
      sel_q <= 1'b0;
      wr_stb_q <= 1'b0;
      rd_req_q <= 1'b0;
      if (lnk.rd_ack && wait_q) begin
        wait_q <= 1'b0;
        rxd_q <= lnk.rd_data;
        if (poll_q) begin
          pollbit_q <= lnk.rd_data[0]; // R22
        end
      end
      if (crcph_q == 2'h1) begin
        wr_stb_q <= 1'b1;
        wr_byte_q <= ~crc_q[15:8]; // R21
        crcph_q <= 2'h0;
      end else if (wr_acc && !busy) begin
        if (i_paddr == `SWB_REG_DATA) begin
          wr_stb_q <= 1'b1; // R2 R10
          wr_byte_q <= i_pwdata[7:0];
          crc_q <= swb_crc_upd(crc_q, i_pwdata[7:0]); // R21
        end else if (i_paddr == `SWB_REG_CTRL) begin
          if (i_pwdata[`SWB_CTL_RESET]) begin
            sel_q <= 1'b1;
            crc_q <= 16'h0000;
            pollbit_q <= 1'b1; // R22
          end else if (i_pwdata[`SWB_CTL_POLL] || i_pwdata[`SWB_CTL_READ]) begin
            rd_req_q <= 1'b1;
            rd_byte_q <= i_pwdata[`SWB_CTL_READ];
            poll_q <= ~i_pwdata[`SWB_CTL_READ];
            wait_q <= 1'b1;
          end else if (i_pwdata[`SWB_CTL_CRC]) begin
            wr_stb_q <= 1'b1;
            wr_byte_q <= ~crc_q[7:0]; // R21
            crcph_q <= 2'h1;
          end
        end
      end
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign lnk.sel = sel_q;
  assign lnk.wr_stb = wr_stb_q;
  assign lnk.wr_byte = wr_byte_q;
  assign lnk.rd_req = rd_req_q;
  assign lnk.rd_byte = rd_byte_q;
endmodule : swb_host
`default_nettype wire

// ===== tb/swb_link_sva.sv
`default_nettype none
module swb_link_sva (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // link
  input wire logic sel,
  input wire logic rd_req,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data,
  // pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wake_req,
  input wire logic o_awake,
  input wire logic o_error_flag_n
);
  logic [9:0] hi_q;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // saturating count of cycles with scl high
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hi_q <= 10'h000;
    end else begin
      hi_q <= !i_scl ? 10'h000 : ((&hi_q) ? hi_q : hi_q + 10'h001);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (rd_req && o_awake |=> rd_ack) else $error("no answer");
  a_ack_cause: assert property (rd_ack |-> $past(rd_req)) else $error("stray answer");
  a_data_hold: assert property (!rd_req |=> $stable(rd_data)) else $error("data moved");
  a_scl_high: assert property ($fell(i_scl) |-> hi_q >= 10'h032) else $error("short high");
  a_sleep_quiet: assert property (!o_awake |-> !rd_ack) else $error("answer asleep");
  a_sleep_free: assert property (!o_awake |-> i_scl && i_sda) else $error("bus held");
  a_wake_up: assert property ($rose(i_wake_req) && !o_awake |-> ##[1:4] o_awake)
    else $error("no wake");
  a_flag_sel: assert property ($rose(o_error_flag_n) |-> $past(sel)) else $error("flag");
endmodule : swb_link_sva
`default_nettype wire

// ===== tb/test_single_wire_to_i2c_command_bridge.sv
`default_nettype none
`include "swb_map.svh"
module test_single_wire_to_i2c_command_bridge;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] e; bit c;} swb_note_t;
  typedef logic [7:0] swb_bytes_t[$];
  localparam logic [7:0] PAT = 8'h96;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, slp = 1'b1, wk = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pd = 32'h0, prd, rd;
  logic prdy, perr, pe, scl_oe, sda_oe, awk, errn, s_scl = 1'b0, s_sda = 1'b0;
  logic ack_en = 1'b1, str_en = 1'b0, sq = 1'b1, dq = 1'b1, ad = 1'b0, rdm = 1'b0;
  logic [3:0] bc = 4'h0;
  logic [7:0] sc = 8'h00;
  int error_cnt = 0, n_compared = 0;
  swb_note_t q[$];
  wire scl = !(scl_oe | s_scl);
  wire sda = !(sda_oe | s_sda);
  swb_link_if lnk ();
  swb_host i_swb_host (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .lnk(lnk));
  swb_dev i_swb_dev (.i_clk_sys(clk), .i_rst(rst), .lnk(lnk), .i_scl(scl), .o_scl_o(),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe), .i_sleep_req(slp),
    .i_wake_req(wk), .o_awake(awk), .o_error_flag_n(errn));
  swb_link_sva i_swb_link_sva (.i_clk_sys(clk), .i_rst(rst), .sel(lnk.sel),
    .rd_req(lnk.rd_req), .rd_ack(lnk.rd_ack), .rd_data(lnk.rd_data), .i_scl(scl),
    .i_sda(sda), .i_wake_req(wk), .o_awake(awk), .o_error_flag_n(errn));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // i2c slave: acks, answers reads with a fixed pattern, may stretch every low phase
  always @(posedge clk) begin
    if (sq && scl && dq && !sda) begin
      bc = 4'hF;
      ad = 1'b1;
    end
    if (!sq && scl && ad && bc == 4'h7) rdm = sda;
    if (sq && !scl) begin
      if (bc == 4'h8) begin
        bc = 4'h0;
        ad = 1'b0;
      end else bc = bc + 4'h1;
      s_sda <= (bc == 4'h8) ? ack_en && (ad || !rdm) : rdm && !ad && !PAT[3'h7 - bc[2:0]];
      sc = str_en ? 8'hC8 : 8'h00;
    end else if (sc != 8'h00) sc = sc - 8'h01;
    s_scl <= sc != 8'h00;
    sq <= scl;
    dq <= sda;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  // read results are compared in order as they appear
  always @(posedge clk) begin
    if (psel && pen && prdy && !pwr && q.size() > 0) begin
      if (q[0].c) cmp(prd, q[0].e);
      void'(q.pop_front());
    end
  end
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d, input bit c,
      input logic [31:0] e);
    if (!w) q.push_back('{e, c});
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    pe = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 1'b0, 32'h0);
  endtask : wr
  task automatic idle;
    do begin
      apb(1'b0, `SWB_REG_STAT, 32'h0, 1'b0, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask : idle
  task automatic rbyte(input logic [7:0] e);
    wr(`SWB_REG_CTRL, 8'h04);
    idle();
    apb(1'b0, `SWB_REG_DATA, 32'h0, 1'b1, {24'h0, e});
  endtask : rbyte
  task automatic pkt(input swb_bytes_t b, input bit crc);
    wr(`SWB_REG_CTRL, 8'h01);
    foreach (b[i]) wr(`SWB_REG_DATA, b[i]);
    if (crc) wr(`SWB_REG_CTRL, 8'h08);
    idle();
  endtask : pkt
  // poll until done, then error byte and write status byte
  task automatic fin(input bit b1, input logic [7:0] er, input logic [7:0] wb);
    wr(`SWB_REG_CTRL, 8'h02);
    idle();
    apb(1'b0, `SWB_REG_STAT, 32'h0, 1'b1, {30'h0, b1, 1'b0});
    while (rd[1] !== 1'b0) begin
      wr(`SWB_REG_CTRL, 8'h02);
      idle();
    end
    rbyte(er);
    rbyte(wb);
  endtask : fin
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #900000;
    error_cnt++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(58262));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pkt('{`SWB_CMD_CFG_RD}, 1'b0);
    rbyte(8'h01);
    pkt('{`SWB_CMD_CFG_WR, 8'hFF}, 1'b0);
    pkt('{`SWB_CMD_CFG_RD}, 1'b0);
    rbyte(8'h03);
    pkt('{`SWB_CMD_CFG_WR, {6'h00, `SWB_SPD_1M}}, 1'b0);
    cmp({31'h0, errn}, 32'h1);
    str_en <= 1'b1;
    pkt('{`SWB_CMD_WR_STOP, 8'h50, 8'h02, 8'($urandom), 8'($urandom)}, 1'b1);
    fin(1'b1, 8'h00, 8'h00);
    str_en <= 1'b0;
    pkt('{`SWB_CMD_RD_STOP, 8'h50, 8'h02}, 1'b1);
    fin(1'b1, 8'h00, 8'h00);
    rbyte(PAT);
    rbyte(PAT);
    pkt('{`SWB_CMD_WR_RD, 8'h50, 8'h01, 8'($urandom), 8'h01}, 1'b1);
    fin(1'b1, 8'h00, 8'h00);
    rbyte(PAT);
    pkt('{`SWB_CMD_WR_OPEN, 8'h50, 8'h01, 8'($urandom)}, 1'b1);
    fin(1'b1, 8'h00, 8'h00);
    pkt('{`SWB_CMD_WR_ONLY, 8'h01, 8'($urandom)}, 1'b1);
    fin(1'b1, 8'h00, 8'h00);
    pkt('{`SWB_CMD_WR_ONLY_STOP, 8'h01, 8'($urandom)}, 1'b1);
    fin(1'b1, 8'h00, 8'h00);
    pkt('{`SWB_CMD_WR_STOP, 8'h50, 8'h00}, 1'b1);
    cmp({31'h0, errn}, 32'h0);
    pkt('{`SWB_CMD_WR_STOP, 8'h50, 8'h01, 8'h11, 8'($urandom), 8'($urandom)}, 1'b0);
    fin(1'b0, 8'h01, `SWB_WB_NEVER);
    cmp({31'h0, errn}, 32'h0);
    ack_en <= 1'b0;
    pkt('{`SWB_CMD_WR_STOP, 8'h50, 8'h01, 8'($urandom)}, 1'b1);
    fin(1'b1, 8'h02, 8'h00);
    ack_en <= 1'b1;
    pkt('{`SWB_CMD_SLEEP}, 1'b0);
    cmp({31'h0, awk}, 32'h0);
    pkt('{`SWB_CMD_CFG_WR, 8'h00}, 1'b0);
    wk <= 1'b1;
    repeat (5) @(posedge clk);
    cmp({31'h0, awk}, 32'h1);
    pkt('{`SWB_CMD_CFG_RD}, 1'b0);
    rbyte(8'h02);
    slp <= 1'b0;
    wk <= 1'b0;
    repeat (5) @(posedge clk);
    cmp({31'h0, awk}, 32'h0);
    wk <= 1'b1;
    repeat (5) @(posedge clk);
    cmp({31'h0, awk}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0, 1'b0, 32'h0);
    cmp({31'h0, pe}, 32'h1);
    print_verdict();
  end
endmodule : test_single_wire_to_i2c_command_bridge
`default_nettype wire
